// >>> pkg/pmw_pkg.sv
// Constants and types for the power mode and wake-up controller
package pmw_pkg;
  // Register byte offsets on the plain register port
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_SEL = 8'h8f;
  localparam logic [7:0] ADDR_WAKE_MASK = 8'h9f;
  localparam logic [7:0] ADDR_MODE_STATUS = 8'h9e;
  // Power control fields
  localparam int BIT_IDLE = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_SLEEP = 2;
  // Clock select fields
  localparam int CSEL_LO = 0;
  localparam int SETTLE_LO = 2;
  // Reset values
  localparam logic [7:0] WAKE_MASK_RST = 8'hff;
  localparam logic [1:0] SETTLE_RST = 2'h3;
  localparam logic [1:0] CSEL_RST = 2'h0;
  // Clock source codes
  localparam logic [1:0] CSRC_FAST_A = 2'h0;
  localparam logic [1:0] CSRC_SLOW = 2'h1;
  localparam logic [1:0] CSRC_FAST_B = 2'h2;
  localparam logic [1:0] CSRC_EXT = 2'h3;
  // Settling delays in slow-oscillator cycles
  localparam logic [8:0] SETTLE_8 = 9'h008;
  localparam logic [8:0] SETTLE_16 = 9'h010;
  localparam logic [8:0] SETTLE_64 = 9'h040;
  localparam logic [8:0] SETTLE_256 = 9'h100;
  // Sequencer states
  typedef enum logic [2:0] {PMW_RUN, PMW_IDLE, PMW_STOP, PMW_SLEEP, PMW_OSC_UP, PMW_REG_UP} pmw_state_e;
  // Clock and power controls toward the clock tree
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic fast_osc_en;
    logic main_reg_en;
    logic [1:0] clk_src;
    logic wdt_run;
  } pmw_ctrl_s;
endpackage

// >>> rtl/pmw_top.sv
// Power mode sequencer with masked edge wake-up from external lines
`timescale 1ns/1ps
// Overview of operation
// [R1] Eight-bit wake mask, bits 7..0 map irq8,7,6,4,3,2,1,0; reset all ones.
// [R2] Wake requests come from edges of enabled lines, whatever the interrupt trigger mode.
// [R3] Wake path ignores interrupt enables; unenabled waker resumes at next instruction.
// [R4] On wake, fast oscillator turns on first, system clock resumes afterwards.
// [R5] In stop or sleep only pins and unclocked sources may wake.
// [R6] Idle gates CPU clock only; other peripherals keep clock and interrupts.
// [R7] In idle, tightly coupled peripherals inaccessible, no instruction processing.
// [R8] Idle ends on pin reset, enabled external irq, or OR-merged peripheral irq.
// [R9] Idle exit vectors to waker's routine; hardware clears idle bit.
// [R10] Stop gates all system clocks and disables fast oscillator after last edge.
// [R11] Wake or reset ends stop; stop bit cleared, oscillator restarted, settings kept.
// [R12] Interrupt ending stop vectors at once; return follows stop instruction.
// [R13] Software should select fast oscillator and quiet peripherals before stop.
// [R14] Sleep disables main regulator; backup regulator and slow oscillator keep running.
// [R15] Sleep ends like stop, regulator on, settling delay on slow clock, then clock.
// [R16] System clock source: divided fast oscillator, slow oscillator or external clock.
// [R17] CPU watchdog stops counting whenever CPU clock is gated.
// [R18] Sleep and stop bits set means sleep; stop alone means stop; both auto-clear.
// [R19] Settling select codes give 8, 16, 64, 256 slow cycles; 256 at reset.
// [R20] Clock select codes 00,10 fast, 01 slow, 11 external; fast after reset.
// [R21] Wake edges latch with no running clock, released once clocks restored.
module pmw_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External lines ext_irq8,7,6,4,3,2,1,0 and merged peripheral irq
  input wire logic [7:0] ext_irq,
  input wire logic periph_irq,
  input wire logic reset_pin_n,
  // Slow oscillator tick, an asynchronous clock sampled here
  input wire logic slow_osc,
  input wire logic fast_osc_ready,
  // Controls and CPU signals
  output pmw_pkg::pmw_ctrl_s ctrl,
  output logic wake_pulse,
  output logic [7:0] wake_src,
  output logic cpu_halted
);
  logic [7:0] wake_source_mask_r;
  logic [1:0] clock_source_sel_r;
  logic [1:0] regulator_settle_sel_r;
  logic idle_r;
  logic stop_r;
  logic sleep_r;
  pmw_pkg::pmw_state_e state_r;
  logic [7:0] irq_s1_r;
  logic [7:0] irq_s2_r;
  logic [7:0] irq_s3_r;
  logic [7:0] wake_lat_r;
  logic pirq_s1_r;
  logic pirq_s2_r;
  logic rpin_s1_r;
  logic rpin_s2_r;
  logic slow_s1_r;
  logic slow_s2_r;
  logic slow_s3_r;
  logic osr_s1_r;
  logic osr_s2_r;
  logic [8:0] settle_cnt_r;
  logic [8:0] settle_len;
  logic slow_tick;
  logic [7:0] wake_edge;
  logic wake_any;
  logic idle_exit;
  logic clocks_back;
  logic [7:0] rd_mux;

  // Synchronisers for all pins from other domains
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      irq_s3_r <= '0;
      pirq_s1_r <= 1'b0;
      pirq_s2_r <= 1'b0;
      rpin_s1_r <= 1'b1;
      rpin_s2_r <= 1'b1;
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
      slow_s3_r <= 1'b0;
      osr_s1_r <= 1'b0;
      osr_s2_r <= 1'b0;
    end
    else
    begin
      irq_s1_r <= ext_irq;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      pirq_s1_r <= periph_irq;
      pirq_s2_r <= pirq_s1_r;
      rpin_s1_r <= reset_pin_n;
      rpin_s2_r <= rpin_s1_r;
      slow_s1_r <= slow_osc;
      slow_s2_r <= slow_s1_r;
      slow_s3_r <= slow_s2_r;
      osr_s1_r <= fast_osc_ready;
      osr_s2_r <= osr_s1_r;
    end
  end

  // Rising edges of enabled lines, independent of interrupt trigger mode
  assign wake_edge = irq_s2_r & ~irq_s3_r & wake_source_mask_r; // [R2] [R1] [R3]
  assign wake_any = |(wake_lat_r | wake_edge);
  assign slow_tick = slow_s2_r & ~slow_s3_r;
  assign clocks_back = (state_r == pmw_pkg::PMW_RUN);
  // Idle ends on reset pin, external line or merged peripheral irq
  assign idle_exit = (|(irq_s2_r & wake_source_mask_r)) | pirq_s2_r | ~rpin_s2_r; // [R8]

  // Wake latch holds the request until clocks are restored
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      wake_lat_r <= '0;
    else if (clocks_back)
      wake_lat_r <= '0; // [R21]
    else if (state_r == pmw_pkg::PMW_STOP || state_r == pmw_pkg::PMW_SLEEP)
      wake_lat_r <= wake_lat_r | wake_edge; // [R5] [R21]
  end

  // Settling length from the select code
  always_comb
  begin
    case (regulator_settle_sel_r)
      2'h0: settle_len = pmw_pkg::SETTLE_8; // [R19]
      2'h1: settle_len = pmw_pkg::SETTLE_16;
      2'h2: settle_len = pmw_pkg::SETTLE_64;
      default: settle_len = pmw_pkg::SETTLE_256;
    endcase
  end

  // Mode sequencer
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      state_r <= pmw_pkg::PMW_RUN;
    else
    begin
      case (state_r)
        pmw_pkg::PMW_RUN:
          if (stop_r && sleep_r)
            state_r <= pmw_pkg::PMW_SLEEP; // [R18]
          else if (stop_r)
            state_r <= pmw_pkg::PMW_STOP; // [R10]
          else if (idle_r)
            state_r <= pmw_pkg::PMW_IDLE; // [R6]
        pmw_pkg::PMW_IDLE:
          if (idle_exit)
            state_r <= pmw_pkg::PMW_RUN; // [R9]
        pmw_pkg::PMW_STOP:
          if (wake_any || !rpin_s2_r)
            state_r <= pmw_pkg::PMW_OSC_UP; // [R11]
        pmw_pkg::PMW_SLEEP:
          if (wake_any || !rpin_s2_r)
            state_r <= pmw_pkg::PMW_REG_UP; // [R15]
        pmw_pkg::PMW_REG_UP:
          if (slow_tick && settle_cnt_r + 9'h001 >= settle_len)
            state_r <= pmw_pkg::PMW_OSC_UP; // [R15]
        pmw_pkg::PMW_OSC_UP:
          if (osr_s2_r)
            state_r <= pmw_pkg::PMW_RUN; // [R4]
        default:
          state_r <= pmw_pkg::PMW_RUN;
      endcase
    end
  end

  // Regulator settling counter on slow oscillator ticks
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      settle_cnt_r <= '0;
    else if (state_r != pmw_pkg::PMW_REG_UP)
      settle_cnt_r <= '0;
    else if (slow_tick)
      settle_cnt_r <= settle_cnt_r + 9'h001; // [R15]
  end

  // Wake pulse and source at return to run
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wake_pulse <= 1'b0;
      wake_src <= '0;
    end
    else
    begin
      wake_pulse <= (state_r == pmw_pkg::PMW_OSC_UP && osr_s2_r)
        || (state_r == pmw_pkg::PMW_IDLE && idle_exit); // [R9] [R12]
      if (state_r == pmw_pkg::PMW_OSC_UP && osr_s2_r)
        wake_src <= wake_lat_r;
      else if (state_r == pmw_pkg::PMW_IDLE && idle_exit)
        wake_src <= irq_s2_r & wake_source_mask_r;
    end
  end

  // Software registers; hardware exit clear wins over a write
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wake_source_mask_r <= pmw_pkg::WAKE_MASK_RST; // [R1]
      clock_source_sel_r <= pmw_pkg::CSEL_RST; // [R20] [R16]
      regulator_settle_sel_r <= pmw_pkg::SETTLE_RST; // [R19]
      idle_r <= 1'b0;
      stop_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == pmw_pkg::ADDR_WAKE_MASK)
        wake_source_mask_r <= reg_wdata;
      if (reg_wr && reg_addr == pmw_pkg::ADDR_CLOCK_SEL)
      begin
        clock_source_sel_r <= reg_wdata[pmw_pkg::CSEL_LO +: 2];
        regulator_settle_sel_r <= reg_wdata[pmw_pkg::SETTLE_LO +: 2];
      end
      if (state_r == pmw_pkg::PMW_IDLE && idle_exit)
        idle_r <= 1'b0; // [R9]
      else if (state_r == pmw_pkg::PMW_OSC_UP && osr_s2_r)
      begin
        stop_r <= 1'b0; // [R11] [R18]
        sleep_r <= 1'b0;
      end
      else if (reg_wr && reg_addr == pmw_pkg::ADDR_POWER_CTRL && state_r == pmw_pkg::PMW_RUN)
      begin
        idle_r <= reg_wdata[pmw_pkg::BIT_IDLE];
        stop_r <= reg_wdata[pmw_pkg::BIT_STOP];
        sleep_r <= reg_wdata[pmw_pkg::BIT_SLEEP];
      end
    end
  end

  // Read mux
  always_comb
  begin
    if (reg_addr == pmw_pkg::ADDR_WAKE_MASK)
      rd_mux = wake_source_mask_r;
    else if (reg_addr == pmw_pkg::ADDR_CLOCK_SEL)
      rd_mux = {4'h0, regulator_settle_sel_r, clock_source_sel_r};
    else if (reg_addr == pmw_pkg::ADDR_POWER_CTRL)
      rd_mux = {5'h00, sleep_r, stop_r, idle_r};
    else if (reg_addr == pmw_pkg::ADDR_MODE_STATUS)
      rd_mux = {5'h00, state_r};
    else
      rd_mux = 8'h00;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Clock and power controls
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ctrl <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, fast_osc_en: 1'b1, main_reg_en: 1'b1,
        clk_src: pmw_pkg::CSRC_FAST_A, wdt_run: 1'b1};
      cpu_halted <= 1'b0;
    end
    else
    begin
      ctrl.cpu_clk_en <= (state_r == pmw_pkg::PMW_RUN); // [R6] [R7]
      ctrl.periph_clk_en <= (state_r == pmw_pkg::PMW_RUN) || (state_r == pmw_pkg::PMW_IDLE); // [R6] [R10]
      ctrl.fast_osc_en <= (state_r != pmw_pkg::PMW_STOP) && (state_r != pmw_pkg::PMW_SLEEP)
        && (state_r != pmw_pkg::PMW_REG_UP); // [R10] [R4]
      ctrl.main_reg_en <= (state_r != pmw_pkg::PMW_SLEEP); // [R14]
      ctrl.clk_src <= (clock_source_sel_r == pmw_pkg::CSRC_FAST_B) ? pmw_pkg::CSRC_FAST_A
        : clock_source_sel_r; // [R20] [R11]
      ctrl.wdt_run <= (state_r == pmw_pkg::PMW_RUN); // [R17]
      cpu_halted <= (state_r != pmw_pkg::PMW_RUN); // [R7]
    end
  end

  // Checks
  sleep_regoff_a: assert property (@(posedge clk_sys) disable iff (reset) // [R14]
    state_r == pmw_pkg::PMW_SLEEP |=> !ctrl.main_reg_en)
    else $error("regulator on in sleep");
  osc_first_a: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    $rose(ctrl.cpu_clk_en) |-> $past(ctrl.fast_osc_en))
    else $error("clock resumed before oscillator");
  stop_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
    state_r == pmw_pkg::PMW_STOP |=> !ctrl.periph_clk_en && !ctrl.fast_osc_en)
    else $error("clocks alive in stop");
  idle_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // [R6]
    state_r == pmw_pkg::PMW_IDLE |=> !ctrl.cpu_clk_en && ctrl.periph_clk_en)
    else $error("idle gating wrong");
  wdt_halt_a: assert property (@(posedge clk_sys) disable iff (reset) // [R17]
    !ctrl.cpu_clk_en |-> !ctrl.wdt_run)
    else $error("watchdog runs while cpu gated");
  sleep_entry_a: assert property (@(posedge clk_sys) disable iff (reset) // [R18]
    state_r == pmw_pkg::PMW_RUN && stop_r && sleep_r |=> state_r == pmw_pkg::PMW_SLEEP)
    else $error("sleep not entered");
  mask_block_a: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    state_r == pmw_pkg::PMW_STOP && !(|wake_lat_r) && !(|wake_edge) && rpin_s2_r
    |=> state_r == pmw_pkg::PMW_STOP)
    else $error("stop left without wake");
  bits_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
    state_r == pmw_pkg::PMW_OSC_UP && osr_s2_r |=> !stop_r && !sleep_r && wake_pulse)
    else $error("stop bits not cleared");
  csel_map_a: assert property (@(posedge clk_sys) disable iff (reset) // [R20]
    clock_source_sel_r == pmw_pkg::CSRC_FAST_B |=> ctrl.clk_src == pmw_pkg::CSRC_FAST_A)
    else $error("clock select map wrong");
  cov_idle_c: cover property (@(posedge clk_sys) state_r == pmw_pkg::PMW_IDLE ##1 state_r == pmw_pkg::PMW_RUN);
  cov_stop_c: cover property (@(posedge clk_sys) state_r == pmw_pkg::PMW_STOP ##1 state_r == pmw_pkg::PMW_OSC_UP);
  cov_sleep_c: cover property (@(posedge clk_sys) state_r == pmw_pkg::PMW_REG_UP ##1 state_r == pmw_pkg::PMW_OSC_UP);
endmodule

// >>> testbench/pmw_osc_model.sv
// Clock source model: fast oscillator start-up and free-running slow oscillator
`timescale 1ns/1ps
module pmw_osc_model #(
  parameter int START_CYC = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Oscillator control and status
  input wire logic fast_osc_en,
  output logic fast_osc_ready,
  output logic slow_osc
);
  int cnt;
  // Slow oscillator never stops, phase unrelated to the system clock
  initial
  begin
    slow_osc = 1'b0;
    #1.3;
    forever #15.3 slow_osc = ~slow_osc;
  end
  // Ready drops at once when disabled, rises after a start-up count
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 0;
      fast_osc_ready <= 1'b1;
    end
    else if (!fast_osc_en)
    begin
      cnt <= 0;
      fast_osc_ready <= 1'b0;
    end
    else if (cnt < START_CYC)
      cnt <= cnt + 1;
    else
      fast_osc_ready <= 1'b1;
  end
endmodule

// >>> testbench/test_pmw_top.sv
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ps
module test_pmw_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] ext_irq = 8'h00;
  logic periph_irq = 1'b0;
  logic reset_pin_n = 1'b1;
  logic slow_osc;
  logic fast_osc_ready;
  pmw_pkg::pmw_ctrl_s ctrl;
  logic wake_pulse;
  logic [7:0] wake_src;
  logic cpu_halted;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_wake = 0;
  int slow_cnt = 0;
  int s_reg = 0;
  int s_osc = 0;
  realtime t_osc = 0;
  realtime t_cpu = 0;
  logic [7:0] rv;
  // System clock
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  pmw_top i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq(ext_irq), .periph_irq(periph_irq),
    .reset_pin_n(reset_pin_n), .slow_osc(slow_osc), .fast_osc_ready(fast_osc_ready), .ctrl(ctrl),
    .wake_pulse(wake_pulse), .wake_src(wake_src), .cpu_halted(cpu_halted));
  pmw_osc_model i_osc (.clk_sys(clk_sys), .reset(reset), .fast_osc_en(ctrl.fast_osc_en),
    .fast_osc_ready(fast_osc_ready), .slow_osc(slow_osc));
  // Event stamps for ordering and settling checks
  always @(posedge slow_osc) slow_cnt++;
  always @(posedge ctrl.main_reg_en) s_reg = slow_cnt;
  always @(posedge ctrl.fast_osc_en)
  begin
    s_osc = slow_cnt;
    t_osc = $realtime;
  end
  always @(posedge ctrl.cpu_clk_en) t_cpu = $realtime;
  // Wake pulses and hang guard
  always @(posedge clk_sys)
  begin
    if (wake_pulse === 1'b1)
      n_wake++;
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      close_out();
    end
  end
  function automatic int settle(input logic [1:0] c);
    return (c == 2'h0) ? 8 : (c == 2'h1) ? 16 : (c == 2'h2) ? 64 : 256;
  endfunction
  // Source seen by the clock tree for a select code
  function automatic logic [1:0] csrc(input logic [1:0] c);
    return (c == 2'h2) ? 2'h0 : c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_halted !== 1'b0 && n < 4000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(8'(n < 4000), 8'h01, "no return to run");
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic close_out();
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    int b;
    int c;
    int w;
    logic [7:0] m;
    void'($urandom(32'h11ae));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values and an unmapped address
    rd(pmw_pkg::ADDR_WAKE_MASK);
    chk(rv, 8'hff, "mask reset");
    rd(pmw_pkg::ADDR_CLOCK_SEL);
    chk(rv, 8'h0c, "clock select reset");
    rd(8'h10);
    chk(rv, 8'h00, "unmapped read");
    chk({6'h0, ctrl.clk_src}, 8'h00, "default source");
    // Stop: masked line and clocked source ignored, enabled edge wakes
    b = $urandom % 8;
    c = (b + 1 + $urandom % 7) % 8;
    m = (8'($urandom) | (8'h01 << b)) & ~(8'h01 << c);
    wr(pmw_pkg::ADDR_WAKE_MASK, m);
    rd(pmw_pkg::ADDR_WAKE_MASK);
    chk(rv, m, "mask readback");
    wr(pmw_pkg::ADDR_POWER_CTRL, 8'h02);
    repeat (5) @(posedge clk_sys);
    #1;
    chk({ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.fast_osc_en, ctrl.wdt_run, cpu_halted}, 8'h01,
      "stop controls");
    rd(pmw_pkg::ADDR_MODE_STATUS);
    chk(rv, 8'h02, "stop state");
    @(posedge clk_sys);
    ext_irq[c] <= 1'b1;
    periph_irq <= 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    chk({7'h0, cpu_halted}, 8'h01, "woke on masked or clocked source");
    w = n_wake;
    @(posedge clk_sys);
    ext_irq[b] <= 1'b1;
    wait_run();
    chk(8'(n_wake - w), 8'h01, "wake pulse count");
    chk(wake_src & ((8'h01 << b) | (8'h01 << c)), 8'h01 << b, "wake source");
    chk(8'(t_osc < t_cpu), 8'h01, "oscillator before clock");
    rd(pmw_pkg::ADDR_POWER_CTRL);
    chk(rv, 8'h00, "stop bit cleared");
    @(posedge clk_sys);
    ext_irq <= 8'h00;
    periph_irq <= 1'b0;
    // Idle: peripherals keep clock, merged peripheral irq ends it
    wr(pmw_pkg::ADDR_POWER_CTRL, 8'h01);
    repeat (5) @(posedge clk_sys);
    #1;
    chk({ctrl.cpu_clk_en, ctrl.periph_clk_en, ctrl.wdt_run, cpu_halted}, 8'h05, "idle controls");
    @(posedge clk_sys);
    periph_irq <= 1'b1;
    wait_run();
    rd(pmw_pkg::ADDR_POWER_CTRL);
    chk(rv, 8'h00, "idle bit cleared");
    @(posedge clk_sys);
    periph_irq <= 1'b0;
    // Every source and settle code; sleep exit waits the settle count
    for (int k = 0; k < 4; k++)
    begin
      wr(pmw_pkg::ADDR_CLOCK_SEL, 8'(k * 5));
      rd(pmw_pkg::ADDR_CLOCK_SEL);
      chk(rv, 8'(k * 5), "clock select readback");
      chk({6'h0, ctrl.clk_src}, {6'h0, csrc(2'(k))}, "source map");
      wr(pmw_pkg::ADDR_CLOCK_SEL, 8'(k * 4));
      wr(pmw_pkg::ADDR_POWER_CTRL, 8'h06);
      repeat (5) @(posedge clk_sys);
      #1;
      chk({ctrl.main_reg_en, ctrl.cpu_clk_en}, 8'h00, "sleep controls");
      @(posedge clk_sys);
      ext_irq[b] <= 1'b1;
      wait_run();
      w = s_osc - s_reg - settle(2'(k));
      chk(8'(w >= -2 && w <= 2), 8'h01, "settle length");
      rd(pmw_pkg::ADDR_POWER_CTRL);
      chk(rv, 8'h00, "sleep bits cleared");
      @(posedge clk_sys);
      ext_irq[b] <= 1'b0;
    end
    // Pin reset ends stop
    wr(pmw_pkg::ADDR_POWER_CTRL, 8'h02);
    repeat (5) @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    wait_run();
    rd(pmw_pkg::ADDR_POWER_CTRL);
    chk(rv, 8'h00, "stop cleared by pin reset");
    close_out();
  end
endmodule
